// ---- include/tpf_defs.svh ----
// Offsets, field positions, reset values and timing counts of the timer block.
// Function
// - Capture pin event sets capture flag.
// - Capture-as-top mode: flag set at top.
// - Executed vector clears its own flag.
// - Writing one clears a flag bit.
// - Compare B flag set tick after match.
// - Compare A flag set tick after match.
// - Forced compare strobe never sets flags.
// - Overflow flag point follows waveform mode.
// - One shared prescaler, separate clock selects.
// - Select 1 direct; taps 8/64/256/1024.
// - Prescaler free running, first tick 1..N+1.
// - Count pin sampled, then edge detected.
// - Synchroniser clocked on rising clock edge.
// - Select 7 rising, 6 falling edges.
// - Pin edge to update 2.5-3.5 clocks; the timer tick here comes 3 to 4 clocks after the pin edge.
// - External pulses never pass the prescaler.
// - Sync hold keeps prescaler reset asserted.
// - Clearing sync hold clears prescaler reset.
// - Prescaler reset bit self-clears otherwise.
// - Select 0 stops; 2..5 ascending taps.
`ifndef TPF_DEFS_SVH
`define TPF_DEFS_SVH

// ============================================================
// Register byte offsets
`define TPF_OFS_FLAGS 12'h000
`define TPF_OFS_GCTRL 12'h004
`define TPF_OFS_T0CTRL 12'h008
`define TPF_OFS_T1CTRL 12'h00c
`define TPF_OFS_STATUS 12'h010

// ============================================================
// Field positions
`define TPF_BIT_CAPTURE 7
`define TPF_BIT_CMP_B 5
`define TPF_BIT_CMP_A 4
`define TPF_BIT_OVF 3
`define TPF_FLAG_MASK 8'hb8
`define TPF_BIT_SYNC_HOLD 7
`define TPF_BIT_PSR 0
`define TPF_CS_LSB 0
`define TPF_WGM_LSB 4

// ============================================================
// Reset values
`define TPF_RST_FLAGS 8'h00
`define TPF_RST_GCTRL 8'h00
`define TPF_RST_TCTRL 8'h00

// ============================================================
// Clock select codes
`define TPF_CS_STOP 3'h0
`define TPF_CS_DIRECT 3'h1
`define TPF_CS_DIV8 3'h2
`define TPF_CS_DIV64 3'h3
`define TPF_CS_DIV256 3'h4
`define TPF_CS_DIV1024 3'h5
`define TPF_CS_EXT_FALL 3'h6
`define TPF_CS_EXT_RISE 3'h7

// ============================================================
// Prescaler taps as counter low-bit widths (divisor = 2**width)
`define TPF_TAP8_BITS 3
`define TPF_TAP64_BITS 6
`define TPF_TAP256_BITS 8
`define TPF_TAP1024_BITS 10

// ============================================================
// Waveform modes that matter to the flags
`define TPF_WGM_NORMAL 4'h0
`define TPF_WGM_CTC_OCRA 4'h4
`define TPF_WGM_CTC_ICR 4'hc
`define TPF_WGM_FPWM_ICR 4'he

`endif

// ---- include/tpf_pkg.sv ----
// Types shared by the timer prescaler and event flag block.
package tpf_pkg;
	typedef logic [2:0] tpf_csel_type;
	typedef logic [3:0] tpf_wgm_type;
	typedef logic [7:0] tpf_byte_type;
endpackage

// ---- include/tpf_edge_if.sv ----
// Edge pulses from a count pin synchroniser to the clock selector.
`timescale 1ns/10ps
interface tpf_edge_if;
	logic rise;
	logic fall;
	modport src (output rise, output fall);
	modport snk (input rise, input fall);
endinterface

// ---- hw/tpf_pin_edge.sv ----
// Count pin synchroniser and edge detector.
`timescale 1ns/10ps
module tpf_pin_edge
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic count_pin,
	tpf_edge_if.src edge_o
);
	import tpf_pkg::*;

	logic meta_q;
	logic meta_d;
	logic sync_q;
	logic sync_d;
	logic prev_q;
	logic prev_d;
	logic rise_q;
	logic rise_d;
	logic fall_q;
	logic fall_d;

	// ============================================================
	// Synchroniser and edge detector
	// A flop replaces the transparent-high latch; the tick pulse follows the pin edge by 3 to 4 clocks.
	always_comb
	begin
		meta_d = count_pin;
		sync_d = meta_q;
		prev_d = sync_q;
		rise_d = sync_q & ~prev_q;
		fall_d = ~sync_q & prev_q;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
			rise_q <= 1'b0;
			fall_q <= 1'b0;
		end
		else
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			prev_q <= prev_d;
			rise_q <= rise_d;
			fall_q <= fall_d;
		end
	end

	assign edge_o.rise = rise_q;
	assign edge_o.fall = fall_q;
endmodule // tpf_pin_edge

// ---- hw/tpf_top.sv ----
// Shared prescaler, count pin clocking and timer event flags with APB.
`timescale 1ns/10ps
`include "tpf_defs.svh"
module tpf_top
#(
	parameter int PRESCALE_WIDTH = `TPF_TAP1024_BITS
)
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic count_pin0,
	input wire logic count_pin1,
	input wire logic capture_evt,
	input wire logic top_reached,
	input wire logic match_a,
	input wire logic match_b,
	input wire logic force_a,
	input wire logic force_b,
	input wire logic overflow_evt,
	input wire logic mode_ovf_evt,
	input wire logic [3:0] vector_ack,
	output logic timer0_clock_pulse,
	output logic timer1_clock_pulse,
	output tpf_pkg::tpf_byte_type timer_flags,
	output tpf_pkg::tpf_wgm_type waveform_mode,
	output logic prescaler_held
);
	import tpf_pkg::*;

	if (PRESCALE_WIDTH < `TPF_TAP1024_BITS || PRESCALE_WIDTH > 16)
	begin : g_bad_width
		$error("PRESCALE_WIDTH must lie between the 1024 tap and 16");
	end

	// ============================================================
	// Count pin front ends, one per timer
	tpf_edge_if pin0_edges ();
	tpf_edge_if pin1_edges ();

	tpf_pin_edge u_pin0
	(
		.core_clk(core_clk),
		.rst_b(rst_b),
		.count_pin(count_pin0),
		.edge_o(pin0_edges.src)
	);

	tpf_pin_edge u_pin1
	(
		.core_clk(core_clk),
		.rst_b(rst_b),
		.count_pin(count_pin1),
		.edge_o(pin1_edges.src)
	);

	// ============================================================
	// Register state
	tpf_byte_type flags_q;
	tpf_byte_type flags_d;
	logic sync_hold_q;
	logic sync_hold_d;
	logic psr_q;
	logic psr_d;
	tpf_csel_type cs0_q;
	tpf_csel_type cs0_d;
	tpf_csel_type cs1_q;
	tpf_csel_type cs1_d;
	tpf_wgm_type wgm_q;
	tpf_wgm_type wgm_d;
	logic [PRESCALE_WIDTH-1:0] pre_q;
	logic [PRESCALE_WIDTH-1:0] pre_d;
	logic tick0_q;
	logic tick0_d;
	logic tick1_q;
	logic tick1_d;
	logic pend_a_q;
	logic pend_a_d;
	logic pend_b_q;
	logic pend_b_d;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic pready_q;
	logic pready_d;
	logic pslverr_q;
	logic pslverr_d;

	logic tap8;
	logic tap64;
	logic tap256;
	logic tap1024;
	logic setup_ph;
	logic wr_en;
	logic hit;
	logic wr_flags;
	logic wr_gctrl;
	logic [7:0] wbyte;
	logic [3:0] set_ev;
	logic [3:0] clr_ev;
	logic cap_top_mode;
	logic ovf_simple_mode;

	// ============================================================
	// Clock source selection
	function automatic logic pick_tick(input tpf_csel_type cs,
		input logic t8, input logic t64, input logic t256,
		input logic t1024, input logic rise, input logic fall);
		logic r;
		r = 1'b0;
		case (cs)
			`TPF_CS_STOP: r = 1'b0;
			`TPF_CS_DIRECT: r = 1'b1;
			`TPF_CS_DIV8: r = t8;
			`TPF_CS_DIV64: r = t64;
			`TPF_CS_DIV256: r = t256;
			`TPF_CS_DIV1024: r = t1024;
			`TPF_CS_EXT_FALL: r = fall;
			`TPF_CS_EXT_RISE: r = rise;
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	// ============================================================
	// Prescaler and timer clock pulses
	always_comb
	begin
		tap8 = &pre_q[`TPF_TAP8_BITS-1:0];
		tap64 = &pre_q[`TPF_TAP64_BITS-1:0];
		tap256 = &pre_q[`TPF_TAP256_BITS-1:0];
		tap1024 = &pre_q[`TPF_TAP1024_BITS-1:0];
		// Free running; only the reset bit holds it.
		if (psr_q)
			pre_d = '0;
		else
			pre_d = pre_q + 1'b1;
		// Each timer has its own select on the same taps.
		tick0_d = pick_tick(cs0_q, tap8, tap64, tap256, tap1024,
			pin0_edges.snk.rise, pin0_edges.snk.fall);
		tick1_d = pick_tick(cs1_q, tap8, tap64, tap256, tap1024,
			pin1_edges.snk.rise, pin1_edges.snk.fall);
		// Edge pulses reach the counter without division.
		if (psr_q && cs0_q < `TPF_CS_EXT_FALL)
			tick0_d = 1'b0;
		if (psr_q && cs1_q < `TPF_CS_EXT_FALL)
			tick1_d = 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			pre_q <= '0;
			tick0_q <= 1'b0;
			tick1_q <= 1'b0;
		end
		else
		begin
			pre_q <= pre_d;
			tick0_q <= tick0_d;
			tick1_q <= tick1_d;
		end
	end

	// ============================================================
	// APB decode
	always_comb
	begin
		setup_ph = psel & ~penable;
		wr_en = psel & penable & pready_q & pwrite;
		wbyte = pwdata[7:0];
		hit = 1'b1;
		case (paddr)
			`TPF_OFS_FLAGS,
			`TPF_OFS_GCTRL,
			`TPF_OFS_T0CTRL,
			`TPF_OFS_T1CTRL,
			`TPF_OFS_STATUS: hit = 1'b1;
			default: hit = 1'b0;
		endcase
		wr_flags = wr_en & (paddr == `TPF_OFS_FLAGS);
		wr_gctrl = wr_en & (paddr == `TPF_OFS_GCTRL);
	end

	// ============================================================
	// Control registers
	always_comb
	begin
		sync_hold_d = sync_hold_q;
		psr_d = psr_q;
		cs0_d = cs0_q;
		cs1_d = cs1_q;
		wgm_d = wgm_q;
		// Without hold the reset bit lasts one cycle.
		if (!sync_hold_q)
			psr_d = 1'b0;
		if (wr_gctrl)
		begin
			sync_hold_d = wbyte[`TPF_BIT_SYNC_HOLD];
			if (wbyte[`TPF_BIT_SYNC_HOLD])
				psr_d = wbyte[`TPF_BIT_PSR];
			else if (sync_hold_q)
				psr_d = 1'b0;
			else
				psr_d = wbyte[`TPF_BIT_PSR];
		end
		if (wr_en && paddr == `TPF_OFS_T0CTRL)
			cs0_d = wbyte[`TPF_CS_LSB +: 3];
		if (wr_en && paddr == `TPF_OFS_T1CTRL)
		begin
			cs1_d = wbyte[`TPF_CS_LSB +: 3];
			wgm_d = wbyte[`TPF_WGM_LSB +: 4];
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			sync_hold_q <= 1'(`TPF_RST_GCTRL >> `TPF_BIT_SYNC_HOLD);
			psr_q <= 1'b0;
			cs0_q <= `TPF_CS_STOP;
			cs1_q <= `TPF_CS_STOP;
			wgm_q <= `TPF_WGM_NORMAL;
		end
		else
		begin
			sync_hold_q <= sync_hold_d;
			psr_q <= psr_d;
			cs0_q <= cs0_d;
			cs1_q <= cs1_d;
			wgm_q <= wgm_d;
		end
	end

	// ============================================================
	// Event flags
	always_comb
	begin
		cap_top_mode = (wgm_q == `TPF_WGM_CTC_ICR) ||
			(wgm_q == `TPF_WGM_FPWM_ICR);
		ovf_simple_mode = (wgm_q == `TPF_WGM_NORMAL) ||
			(wgm_q == `TPF_WGM_CTC_OCRA) ||
			(wgm_q == `TPF_WGM_CTC_ICR);
		// A match is noted on one timer tick, flagged on the next.
		pend_a_d = pend_a_q;
		pend_b_d = pend_b_q;
		if (tick1_q)
		begin
			pend_a_d = match_a & ~force_a;
			pend_b_d = match_b & ~force_b;
		end
		set_ev[3] = cap_top_mode ? (tick1_q & top_reached)
			: capture_evt;
		set_ev[2] = tick1_q & pend_b_q;
		set_ev[1] = tick1_q & pend_a_q;
		set_ev[0] = ovf_simple_mode ? overflow_evt
			: mode_ovf_evt;
		clr_ev = vector_ack;
		if (wr_flags)
		begin
			clr_ev[3] = clr_ev[3] | wbyte[`TPF_BIT_CAPTURE];
			clr_ev[2] = clr_ev[2] | wbyte[`TPF_BIT_CMP_B];
			clr_ev[1] = clr_ev[1] | wbyte[`TPF_BIT_CMP_A];
			clr_ev[0] = clr_ev[0] | wbyte[`TPF_BIT_OVF];
		end
		// A set in the clearing cycle wins.
		flags_d = flags_q;
		flags_d[`TPF_BIT_CAPTURE] = set_ev[3] |
			(flags_q[`TPF_BIT_CAPTURE] & ~clr_ev[3]);
		flags_d[`TPF_BIT_CMP_B] = set_ev[2] |
			(flags_q[`TPF_BIT_CMP_B] & ~clr_ev[2]);
		flags_d[`TPF_BIT_CMP_A] = set_ev[1] |
			(flags_q[`TPF_BIT_CMP_A] & ~clr_ev[1]);
		flags_d[`TPF_BIT_OVF] = set_ev[0] |
			(flags_q[`TPF_BIT_OVF] & ~clr_ev[0]);
		flags_d = flags_d & `TPF_FLAG_MASK;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			flags_q <= `TPF_RST_FLAGS;
			pend_a_q <= 1'b0;
			pend_b_q <= 1'b0;
		end
		else
		begin
			flags_q <= flags_d;
			pend_a_q <= pend_a_d;
			pend_b_q <= pend_b_d;
		end
	end

	// ============================================================
	// APB answer: one access cycle, read data prepared in setup
	always_comb
	begin
		pready_d = setup_ph;
		pslverr_d = setup_ph & ~hit;
		prdata_d = prdata_q;
		if (setup_ph)
		begin
			prdata_d = '0;
			case (paddr)
				`TPF_OFS_FLAGS: prdata_d[7:0] = flags_q;
				`TPF_OFS_GCTRL:
				begin
					prdata_d[`TPF_BIT_SYNC_HOLD] = sync_hold_q;
					prdata_d[`TPF_BIT_PSR] = psr_q;
				end
				`TPF_OFS_T0CTRL: prdata_d[2:0] = cs0_q;
				`TPF_OFS_T1CTRL:
				begin
					prdata_d[2:0] = cs1_q;
					prdata_d[7:4] = wgm_q;
				end
				`TPF_OFS_STATUS:
				begin
					prdata_d[PRESCALE_WIDTH-1:0] = pre_q;
					prdata_d[16] = psr_q;
				end
				default: prdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			prdata_q <= '0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else
		begin
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	// ============================================================
	// Outputs
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign timer0_clock_pulse = tick0_q;
	assign timer1_clock_pulse = tick1_q;
	assign timer_flags = flags_q;
	assign waveform_mode = wgm_q;
	assign prescaler_held = psr_q;
endmodule // tpf_top

// ---- tb/tpf_ext_clk.sv ----
// Behavioural external clock source that drives the count pins.
`timescale 1ns/10ps
module tpf_ext_clk
#(
	parameter realtime HALF = 8.3
)
(
	input wire logic en,
	output logic pin
);
	// ============================================================
	// Toggle source
	// Half period above one system clock keeps every edge sampled.
	initial pin = 1'b0;
	always
	begin
		#(HALF);
		if (en)
			pin = ~pin;
	end
endmodule // tpf_ext_clk

// ---- tb/tpf_top_checker.sv ----
// Port-level assertions for the timer prescaler and event flags.
`timescale 1ns/10ps
`include "tpf_defs.svh"
module tpf_top_checker
#(
	parameter int PRESCALE_WIDTH = 10
)
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic count_pin1,
	input wire logic capture_evt,
	input wire logic overflow_evt,
	input wire logic mode_ovf_evt,
	input wire logic [3:0] vector_ack,
	input wire logic timer1_clock_pulse,
	input wire tpf_pkg::tpf_byte_type timer_flags,
	input wire tpf_pkg::tpf_wgm_type waveform_mode,
	input wire logic prescaler_held
);
	import tpf_pkg::*;
	// ============================================================
	// Mirror of the timer 1 select and sync hold bit written over the bus
	logic [2:0] cs1_q;
	logic sync_q;
	logic acc;
	logic tk;
	assign acc = psel & penable & pready & pwrite;
	assign tk = timer1_clock_pulse;
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			cs1_q <= 3'h0;
			sync_q <= 1'b0;
		end
		else if (acc && paddr == `TPF_OFS_T1CTRL)
			cs1_q <= pwdata[2:0];
		else if (acc && paddr == `TPF_OFS_GCTRL)
			sync_q <= pwdata[7];
	end
	// ============================================================
	// Assertions
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	AST_CAP: assert property (capture_evt && waveform_mode[3:2] != 2'h3
		|=> timer_flags[7]) else $error("capture flag not set");
	AST_OVF: assert property (overflow_evt && waveform_mode == 4'h0
		|=> timer_flags[3]) else $error("overflow flag not set");
	AST_VEC: assert property (vector_ack[0] && !overflow_evt
		&& !mode_ovf_evt |=> !timer_flags[3]) else $error("ack kept flag");
	AST_RSV: assert property ((timer_flags & 8'h47) == 8'h00)
		else $error("reserved flag bit set");
	AST_EXT: assert property (cs1_q == 3'h7 && $rose(count_pin1)
		|-> ##[1:4] tk) else $error("pin edge gave no tick");
	AST_DIR: assert property ((cs1_q == 3'h1 && !prescaler_held)[*3]
		|-> tk) else $error("direct select missed a tick");
	AST_DIV8: assert property (disable iff (!rst_b || cs1_q != 3'h2
		|| prescaler_held) tk && $past(cs1_q) == 3'h2
		|=> (!tk)[*7] ##1 tk) else $error("divide by 8 spacing wrong");
	AST_PSR: assert property ($rose(prescaler_held) && !sync_q
		|=> !prescaler_held) else $error("prescaler reset stuck");
	cover property (tk && cs1_q == 3'h7);
	cover property (prescaler_held && sync_q);
	cover property (timer_flags[4]);
endmodule // tpf_top_checker
bind tpf_top tpf_top_checker #(.PRESCALE_WIDTH(PRESCALE_WIDTH)) u_chk (
	.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
	.count_pin1, .capture_evt, .overflow_evt, .mode_ovf_evt, .vector_ack,
	.timer1_clock_pulse, .timer_flags, .waveform_mode, .prescaler_held);

// ---- tb/testbench.sv ----
// Self-checking bench for the timer prescaler and event flags.
`timescale 1ns/10ps
`include "tpf_defs.svh"
module testbench;
	import tpf_pkg::*;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, er, t0p, t1p, held, pin;
	logic en = 1'b0;
	logic [11:0] ev = 12'h000;
	wire logic capture_evt, overflow_evt, mode_ovf_evt, top_reached;
	wire logic match_a, match_b, force_a, force_b;
	wire logic [3:0] vector_ack;
	tpf_byte_type flags;
	tpf_wgm_type wgm;
	int n_fail = 0, n_checks = 0, n0, n1, nr, nf, cyc = 0;
	int tap [6] = '{0, 1, 8, 64, 256, 1024};
	// Row layout: waveform mode, {capture, overflow, mode overflow}, flags.
	logic [14:0] rows [7] = '{15'h0480, 15'h0208, 15'h0100, 15'h2208,
		15'h6400, 15'h7108, 15'h7200};
	assign {capture_evt, overflow_evt, mode_ovf_evt, top_reached, match_a,
		match_b, force_a, force_b, vector_ack} = ev;
	tpf_top dut (.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .count_pin0(pin),
		.count_pin1(pin), .capture_evt, .top_reached, .match_a, .match_b,
		.force_a, .force_b, .overflow_evt, .mode_ovf_evt, .vector_ack,
		.timer0_clock_pulse(t0p), .timer1_clock_pulse(t1p),
		.timer_flags(flags), .waveform_mode(wgm), .prescaler_held(held));
	tpf_ext_clk src (.en(en), .pin(pin));
	always #2.5 core_clk = ~core_clk;
	// Ticks are counted on the falling edge so reads at rising edges agree.
	always @(negedge core_clk)
	begin
		n1 += (t1p === 1'b1);
		n0 += (t0p === 1'b1);
	end
	always @(posedge pin) nr++;
	always @(negedge pin) nf++;
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_fail++;
			wrap_up();
		end
	end
	// ============================================================
	// Tasks
	task wrap_up;
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			$display("[FAIL] %s exp %h got %h", s, e, g);
			n_fail++;
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rdchk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk("register read", e, rd);
	endtask
	task pulse(input logic [11:0] v);
		@(posedge core_clk);
		ev <= v;
		@(posedge core_clk);
		ev <= 12'h000;
	endtask
	// ============================================================
	// Main sequence
	initial
	begin
		repeat (12) @(posedge core_clk);
		rst_b <= 1'b1;
		rdchk(`TPF_OFS_FLAGS, 32'h0);
		rdchk(`TPF_OFS_GCTRL, 32'h0);
		apb(1'b0, 12'h100, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, er});
		foreach (rows[i])
		begin
			apb(1'b1, `TPF_OFS_T1CTRL, {24'h0, rows[i][14:11], 4'h0});
			apb(1'b1, `TPF_OFS_FLAGS, 32'hff);
			pulse({rows[i][10:8], 9'h0});
			rdchk(`TPF_OFS_FLAGS, {24'h0, rows[i][7:0]});
			chk("flag pins", {24'h0, rows[i][7:0]}, {24'h0, flags});
		end
		apb(1'b1, `TPF_OFS_T1CTRL, 32'h0);
		apb(1'b1, `TPF_OFS_FLAGS, 32'hff);
		pulse(12'hc00);
		apb(1'b1, `TPF_OFS_FLAGS, 32'h47);
		rdchk(`TPF_OFS_FLAGS, 32'h88);
		apb(1'b1, `TPF_OFS_FLAGS, 32'h08);
		rdchk(`TPF_OFS_FLAGS, 32'h80);
		pulse(12'h400);
		pulse(12'h009);
		rdchk(`TPF_OFS_FLAGS, 32'h0);
		apb(1'b1, `TPF_OFS_T1CTRL, 32'h1);
		pulse(12'h080);
		pulse(12'h0f0);
		rdchk(`TPF_OFS_FLAGS, 32'h10);
		pulse(12'h040);
		rdchk(`TPF_OFS_FLAGS, 32'h30);
		apb(1'b1, `TPF_OFS_T1CTRL, 32'hc1);
		apb(1'b1, `TPF_OFS_FLAGS, 32'hff);
		pulse(12'h100);
		rdchk(`TPF_OFS_FLAGS, 32'h80);
		chk("mode pins", 32'hc, {28'h0, wgm});
		for (int k = 1; k < 6; k++)
		begin
			apb(1'b1, `TPF_OFS_T1CTRL, k);
			repeat (4) @(posedge core_clk);
			n0 = 0;
			n1 = 0;
			repeat (2 * tap[k]) @(posedge core_clk);
			chk("tap ticks", 32'h2, n1);
			chk("stopped ticks", 32'h0, n0);
		end
		apb(1'b1, `TPF_OFS_T1CTRL, 32'h2);
		apb(1'b1, `TPF_OFS_GCTRL, 32'h81);
		n1 = 0;
		repeat (40) @(posedge core_clk);
		chk("held ticks", 32'h0, n1);
		chk("held", 32'h1, {31'h0, held});
		rdchk(`TPF_OFS_STATUS, 32'h10000);
		apb(1'b1, `TPF_OFS_GCTRL, 32'h0);
		@(posedge core_clk);
		chk("released", 32'h0, {31'h0, held});
		n1 = 0;
		repeat (16) @(posedge core_clk);
		chk("resumed ticks", 32'h2, n1);
		apb(1'b1, `TPF_OFS_GCTRL, 32'h1);
		rdchk(`TPF_OFS_GCTRL, 32'h0);
		for (int k = 6; k < 8; k++)
		begin
			apb(1'b1, `TPF_OFS_T1CTRL, k);
			apb(1'b1, `TPF_OFS_T0CTRL, k);
			rdchk(`TPF_OFS_T0CTRL, k);
			n0 = 0;
			n1 = 0;
			nr = 0;
			nf = 0;
			en <= 1'b1;
			repeat (40) @(posedge core_clk);
			en <= 1'b0;
			repeat (10) @(posedge core_clk);
			chk("ext ticks 1", (k == 7) ? nr : nf, n1);
			chk("ext ticks 0", (k == 7) ? nr : nf, n0);
		end
		wrap_up();
	end
endmodule // testbench
